//--- bifl_top.sv
// binary input function logic with apb register file
`timescale 1ns/1ps
module bifl_top
    import bifl_pkg::*;
#(
    parameter int SET_DELAY = SET_DELAY_CYC
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic [31:0]                  prdata,
    input  wire logic [NUM_TERM-1:0]     terminal_in,
    input  wire logic [SPD_W-1:0]        speed_actual,
    input  wire logic [1:0]              set_request,
    output bifl_fn_t                     fn_out,
    output logic [SPD_W-1:0]             speed_ctrl_actual,
    output logic [5:0]                   torque_setpoint_source,
    output logic [SPD_W-1:0]             torque_limit_a,
    output logic [SPD_W-1:0]             torque_limit_b,
    output logic                         rs485_tx_out,
    output logic                         rs485_tx_oe,
    output logic                         rs485_rx_enable,
    input  wire logic                    serial_tx_data,
    output logic [1:0]                   active_set_indicator,
    output logic [1:0]                   display_set_selector,
    output bifl_copy_t                   set_copy_command,
    output logic                         set_copy_start
);

    function automatic logic [NUM_TERM-1:0] hits(input logic [NUM_TERM*CODE_W-1:0] sel,
                                                 input logic [CODE_W-1:0] code);
        logic [NUM_TERM-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_TERM; i++) begin
            m[i] = (sel[i*CODE_W +: CODE_W] == code);
        end
        return m;
    endfunction : hits

    // none assigned gives dflt, otherwise and of the assigned terminals
    function automatic logic all_of(input logic [NUM_TERM-1:0] m,
                                    input logic [NUM_TERM-1:0] t,
                                    input logic dflt);
        return (m == '0) ? dflt : ((t & m) == m);
    endfunction : all_of

    function automatic logic [SPD_W-1:0] mag(input logic [SPD_W-1:0] v);
        return v[SPD_W-1] ? SPD_W'(-v) : v;
    endfunction : mag

    logic [NUM_TERM*CODE_W-1:0] sel_ff;
    logic [7:0]                 tech_droop_amount_ff;
    logic [7:0]                 speed_droop_amount_ff;
    logic [3:0]                 port0_protocol_select_ff;
    logic [3:0]                 port1_protocol_select_ff;
    logic [5:0]                 slave_setpoint_source_ff;
    logic [SPD_W-1:0]           pi_p_speed_threshold_ff;
    logic [SPD_W-1:0]           torque_change_speed_ff;
    logic [2*SPD_W-1:0]         lim_pri_ff;
    logic [2*SPD_W-1:0]         lim_alt_ff;
    logic [1:0]                 display_set_ff;
    bifl_copy_t                 copy_ff;
    logic                       copy_start_ff;
    logic [31:0]                prdata_ff;
    logic                       pslverr_ff;
    logic [NUM_TERM-1:0]        term_meta_ff;
    logic [NUM_TERM-1:0]        term_sync_ff;
    logic [NUM_TERM-1:0]        term_ff;
    logic [CTRL_CNT_W-1:0]      ctrl_cnt_ff;
    logic                       ctrl_tick;
    bifl_fn_t                   fn_ff;
    bifl_fn_t                   nxt_fn;
    logic [SPD_W-1:0]           spd_out_ff;
    logic [5:0]                 trq_src_ff;
    logic [SPD_W-1:0]           lim_a_ff;
    logic [SPD_W-1:0]           lim_b_ff;
    logic [1:0]                 active_set_ff;
    logic [1:0]                 pend_set_ff;
    logic [SET_CNT_W-1:0]       set_cnt_ff;
    logic                       wr_en;
    logic                       rd_setup;
    logic                       addr_ok;
    logic                       peer_mode;

    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign addr_ok  = (paddr[1:0] == 2'b00) && (paddr <= ADDR_LIM_ALT);
    assign pready   = 1'b1;
    assign pslverr  = pslverr_ff & psel & penable;
    assign prdata   = prdata_ff;

    // configuration registers, written at the access edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff                   <= '0;
            tech_droop_amount_ff     <= '0;
            speed_droop_amount_ff    <= '0;
            port0_protocol_select_ff <= '0;
            port1_protocol_select_ff <= '0;
            slave_setpoint_source_ff <= '0;
            pi_p_speed_threshold_ff  <= '0;
            torque_change_speed_ff   <= '0;
            lim_pri_ff               <= '0;
            lim_alt_ff               <= '0;
            display_set_ff           <= '0;
            copy_ff                  <= '0;
        end else if (wr_en && addr_ok) begin
            case (paddr)
                ADDR_SEL_LO: sel_ff[31:0]  <= pwdata;
                ADDR_SEL_HI: sel_ff[63:32] <= pwdata;
                ADDR_CFG: begin
                    tech_droop_amount_ff     <= pwdata[7:0];
                    speed_droop_amount_ff    <= pwdata[15:8];
                    port0_protocol_select_ff <= pwdata[19:16];
                    port1_protocol_select_ff <= pwdata[23:20];
                    slave_setpoint_source_ff <= pwdata[29:24];
                end
                ADDR_SPEED: begin
                    pi_p_speed_threshold_ff <= pwdata[15:0];
                    torque_change_speed_ff  <= pwdata[31:16];
                end
                ADDR_SETCTL: begin
                    display_set_ff <= pwdata[1:0];
                    copy_ff        <= bifl_copy_t'(pwdata[8:4]);
                end
                ADDR_LIM_PRI: lim_pri_ff <= pwdata;
                ADDR_LIM_ALT: lim_alt_ff <= pwdata;
                default: ;
            endcase
        end
    end

    // copy or swap request is a pulse to the parameter store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            copy_start_ff <= 1'b0;
        end else begin
            copy_start_ff <= wr_en && (paddr == ADDR_SETCTL) && pwdata[9];
        end
    end

    // read data is captured in the setup cycle so it comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= RST_ZERO;
            pslverr_ff <= 1'b0;
        end else if (rd_setup) begin
            pslverr_ff <= ~addr_ok;
            case (paddr)
                ADDR_SEL_LO:  prdata_ff <= sel_ff[31:0];
                ADDR_SEL_HI:  prdata_ff <= sel_ff[63:32];
                ADDR_CFG:     prdata_ff <= {2'b00, slave_setpoint_source_ff,
                                            port1_protocol_select_ff, port0_protocol_select_ff,
                                            speed_droop_amount_ff, tech_droop_amount_ff};
                ADDR_SPEED:   prdata_ff <= {torque_change_speed_ff, pi_p_speed_threshold_ff};
                ADDR_SETCTL:  prdata_ff <= {23'h0, copy_ff, 2'b00, display_set_ff};
                ADDR_STATUS:  prdata_ff <= {2'b00, active_set_ff, 4'h0, term_ff,
                                            7'h0, fn_ff};
                ADDR_LIM_PRI: prdata_ff <= lim_pri_ff;
                ADDR_LIM_ALT: prdata_ff <= lim_alt_ff;
                default:      prdata_ff <= RST_ZERO;
            endcase
        end
    end

    // terminals are asynchronous pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_meta_ff <= '0;
            term_sync_ff <= '0;
        end else begin
            term_meta_ff <= terminal_in;
            term_sync_ff <= term_meta_ff;
        end
    end

    // control cycle divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_cnt_ff <= '0;
        end else if (ctrl_cnt_ff == CTRL_CNT_W'(CTRL_CYCLES - 1)) begin
            ctrl_cnt_ff <= '0;
        end else begin
            ctrl_cnt_ff <= ctrl_cnt_ff + 1'b1;
        end
    end
    assign ctrl_tick = (ctrl_cnt_ff == CTRL_CNT_W'(CTRL_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_ff <= '0;
        end else if (ctrl_tick) begin
            term_ff <= term_sync_ff;
        end
    end

    // functions are derived from the snapshot, so terminal changes reach them all on the same tick; p_mode and torque_alt also follow speed_actual
    always_comb begin
        logic [SPD_W-1:0] spd;
        spd                   = mag(speed_actual);
        nxt_fn                = '0;
        nxt_fn.tech_droop     = ((hits(sel_ff, FN_TECH_DROOP) == '0) ||
                                 |(hits(sel_ff, FN_TECH_DROOP) & term_ff)) &&
                                (tech_droop_amount_ff != '0);
        nxt_fn.speed_droop    = all_of(hits(sel_ff, FN_SPD_DROOP), term_ff, 1'b1) &&
                                (speed_droop_amount_ff != '0);
        nxt_fn.pi_to_p_enable = all_of(hits(sel_ff, FN_PI_TO_P), term_ff, 1'b0);
        nxt_fn.p_mode         = nxt_fn.pi_to_p_enable &&
                                (spd > pi_p_speed_threshold_ff);
        nxt_fn.inertia_comp   = all_of(hits(sel_ff, FN_INERTIA), term_ff, 1'b1);
        nxt_fn.speed_invert   = |(hits(sel_ff, FN_SPD_INVERT) & term_ff);
        nxt_fn.slave          = |(hits(sel_ff, FN_MS_SELECT) & term_ff);
        nxt_fn.torque_alt     = |(hits(sel_ff, FN_TRQ_CHANGE) & term_ff) &&
                                (spd > torque_change_speed_ff);
        nxt_fn.main_setpoint_on = all_of(hits(sel_ff, FN_MAIN_SETP), term_ff, 1'b1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fn_ff <= '0;
        end else begin
            fn_ff <= nxt_fn;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_out_ff <= '0;
        end else begin
            spd_out_ff <= fn_ff.speed_invert ? SPD_W'(-speed_actual) : speed_actual;
        end
    end

    // source code 0 means own speed controller output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trq_src_ff <= '0;
        end else begin
            trq_src_ff <= fn_ff.slave ? slave_setpoint_source_ff : 6'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_a_ff <= '0;
            lim_b_ff <= '0;
        end else if (fn_ff.torque_alt) begin
            lim_a_ff <= lim_alt_ff[15:0];
            lim_b_ff <= lim_alt_ff[31:16];
        end else begin
            lim_a_ff <= lim_pri_ff[15:0];
            lim_b_ff <= lim_pri_ff[31:16];
        end
    end

    // rs485 direction: outside peer mode the port is a normal duplex line.
    // the master role swap timing belongs to the supervisor; no interlock here.
    assign peer_mode       = (port0_protocol_select_ff == PROTO_PEER);
    assign rs485_tx_oe     = peer_mode ? ~fn_ff.slave : 1'b1;
    assign rs485_rx_enable = peer_mode ? fn_ff.slave : 1'b1;
    assign rs485_tx_out    = serial_tx_data & rs485_tx_oe;

    // active set follows the request after a settle delay below the 25 ms bound;
    // a request that changes again restarts the wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_set_ff <= '0;
            pend_set_ff   <= '0;
            set_cnt_ff    <= '0;
        end else if (set_request != pend_set_ff) begin
            pend_set_ff <= set_request;
            set_cnt_ff  <= '0;
        end else if (pend_set_ff != active_set_ff) begin
            if (set_cnt_ff >= SET_CNT_W'(SET_DELAY - 2)) begin
                active_set_ff <= pend_set_ff;
                set_cnt_ff    <= '0;
            end else begin
                set_cnt_ff <= set_cnt_ff + 1'b1;
            end
        end
    end

    assign fn_out                 = fn_ff;
    assign speed_ctrl_actual      = spd_out_ff;
    assign torque_setpoint_source = trq_src_ff;
    assign torque_limit_a         = lim_a_ff;
    assign torque_limit_b         = lim_b_ff;
    assign active_set_indicator   = active_set_ff;
    assign display_set_selector   = display_set_ff;
    assign set_copy_command       = copy_ff;
    assign set_copy_start         = copy_start_ff;

endmodule : bifl_top

//--- bifl_pkg.sv
// constants, types and register map of the binary input function logic
package bifl_pkg;
    localparam int          NUM_TERM       = 8;
    localparam int          CODE_W         = 8;
    localparam int          SPD_W          = 16;
    localparam logic [7:0]  FN_TECH_DROOP  = 8'h24;
    localparam logic [7:0]  FN_SPD_DROOP   = 8'h25;
    localparam logic [7:0]  FN_PI_TO_P     = 8'h26;
    localparam logic [7:0]  FN_INERTIA     = 8'h27;
    localparam logic [7:0]  FN_SPD_INVERT  = 8'h28;
    localparam logic [7:0]  FN_MS_SELECT   = 8'h29;
    localparam logic [7:0]  FN_TRQ_CHANGE  = 8'h2a;
    localparam logic [7:0]  FN_MAIN_SETP   = 8'h2b;
    localparam logic [3:0]  PROTO_PEER     = 4'h4;
    localparam logic [7:0]  ADDR_SEL_LO    = 8'h00;
    localparam logic [7:0]  ADDR_SEL_HI    = 8'h04;
    localparam logic [7:0]  ADDR_CFG       = 8'h08;
    localparam logic [7:0]  ADDR_SPEED     = 8'h0c;
    localparam logic [7:0]  ADDR_SETCTL    = 8'h10;
    localparam logic [7:0]  ADDR_STATUS    = 8'h14;
    localparam logic [7:0]  ADDR_LIM_PRI   = 8'h18;
    localparam logic [7:0]  ADDR_LIM_ALT   = 8'h1c;
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
    localparam int          CLK_MHZ        = 250;
    localparam int          CTRL_CYCLE_NS  = 1000;
    localparam int          CTRL_CYCLES    = CTRL_CYCLE_NS * CLK_MHZ / 1000;
    localparam int          SET_DELAY_MS   = 25;
    localparam int          SET_DELAY_CYC  = SET_DELAY_MS * CLK_MHZ * 1000;
    localparam int          MS_SWAP_MS     = 500;
    localparam int          CTRL_CNT_W     = 8;
    localparam int          SET_CNT_W      = 23;

    typedef struct packed {
        logic tech_droop;
        logic speed_droop;
        logic pi_to_p_enable;
        logic p_mode;
        logic inertia_comp;
        logic speed_invert;
        logic slave;
        logic torque_alt;
        logic main_setpoint_on;
    } bifl_fn_t;

    typedef struct packed {
        logic [1:0] src;
        logic [1:0] dst;
        logic       swap;
    } bifl_copy_t;
endpackage : bifl_pkg

//--- bifl_properties.sv
// assertion checker bound to the binary input function logic top
`timescale 1ns/1ps
module bifl_props
    import bifl_pkg::*;
#(
    parameter int SET_DELAY = 20
) (
    input logic             pclk,
    input logic             presetn,
    input logic             psel,
    input logic             penable,
    input logic             pwrite,
    input logic [7:0]       paddr,
    input logic [31:0]      pwdata,
    input bifl_fn_t         fn_out,
    input logic [SPD_W-1:0] speed_actual,
    input logic [SPD_W-1:0] speed_ctrl_actual,
    input logic [5:0]       torque_setpoint_source,
    input logic             rs485_tx_out,
    input logic             rs485_tx_oe,
    input logic             rs485_rx_enable,
    input logic             serial_tx_data,
    input logic [1:0]       set_request,
    input logic [1:0]       active_set_indicator,
    input logic             set_copy_start
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0]  live_ff;
    logic [31:0] held_ff;
    logic        peer_ff;
    logic        live;
    logic        copy_req;
    assign live = live_ff == 2'h3;
    assign copy_req = psel && penable && pwrite && paddr == ADDR_SETCTL && pwdata[9];
    // registered outputs still hold reset values for the first edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) live_ff <= 2'h0;
        else if (!live) live_ff <= live_ff + 2'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) held_ff <= 32'h0;
        else if ($changed(set_request)) held_ff <= 32'h0;
        else if (held_ff < 32'hffff) held_ff <= held_ff + 32'h1;
    end
    // port 0 protocol digit mirrored from bus writes, since it is not a port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) peer_ff <= 1'b0;
        else if (psel && penable && pwrite && paddr == ADDR_CFG)
            peer_ff <= (pwdata[19:16] == PROTO_PEER);
    end
    sequence s_copy;
        copy_req;
    endsequence
    property p_copy;
        s_copy |=> set_copy_start ##1 !set_copy_start;
    endproperty
    AST_COPY_PULSE: assert property (p_copy)
        else $error("copy start is not a single pulse after the command");
    AST_COPY_CAUSE: assert property (set_copy_start |-> $past(copy_req))
        else $error("copy start without a copy command");
    AST_SET_LATE: assert property ($changed(active_set_indicator) |->
        active_set_indicator == set_request && held_ff + 2 >= SET_DELAY && held_ff <= SET_DELAY + 2)
        else $error("active set moved at the wrong time");
    AST_SET_DUE: assert property (held_ff == SET_DELAY + 3 |->
        active_set_indicator == set_request)
        else $error("active set not taken over in time");
    AST_BUS_DIR: assert property (peer_ff ?
        (rs485_rx_enable == fn_out.slave && rs485_tx_oe == !fn_out.slave) :
        (rs485_tx_oe && rs485_rx_enable))
        else $error("bus direction does not follow the master role");
    AST_TX_LINE: assert property (rs485_tx_out == (serial_tx_data && rs485_tx_oe))
        else $error("transmit line driven while released");
    AST_PMODE: assert property (fn_out.p_mode |-> fn_out.pi_to_p_enable)
        else $error("proportional mode without changeover enable");
    AST_INVERT: assert property (live && $stable(speed_actual) && $stable(fn_out.speed_invert)
        |-> speed_ctrl_actual == (fn_out.speed_invert ? -speed_actual : speed_actual))
        else $error("speed actual value polarity wrong");
    AST_SOURCE: assert property (live && $stable(fn_out.slave) && !fn_out.slave
        |-> torque_setpoint_source == 6'h00)
        else $error("master takes a foreign torque setpoint");
endmodule : bifl_props

//--- bifl_switch_model.sv
// model of the switches and supervisor that drive the binary terminals
`timescale 1ns/1ps
module bifl_switch_model
    import bifl_pkg::*;
(
    input logic                 pclk,
    input logic [NUM_TERM-1:0]  want,
    output logic [NUM_TERM-1:0] terminal_in = 8'h00,
    output logic                serial_tx_data = 1'b0
);
    // the supervisor moves a terminal only on command, so any master handover
    // is ordered by the bench, old master to slave first
    // sets are selected only after being set up, never edited on the fly
    always @(posedge pclk) terminal_in <= want;
    // toggling every cycle so a stale transmit bit cannot pass unseen
    always @(posedge pclk) serial_tx_data <= ~serial_tx_data;
endmodule : bifl_switch_model

//--- bifl_top_tb.sv
// self-checking testbench for the binary input function logic
`timescale 1ns/1ps
module bifl_top_tb;
    import bifl_pkg::*;
    localparam int SET_DELAY = 20;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  want = 8'h00;
    logic [15:0] spd = 16'h0;
    logic [1:0]  set_req = 2'h0;
    logic        pready, pslverr, tx_data, tx_out, tx_oe, rx_en, copy_go;
    logic [31:0] prdata;
    logic [7:0]  term, tda, sda;
    logic [15:0] sca, lim_a, lim_b, thr, chg;
    logic [5:0]  src_out;
    logic [1:0]  act, disp;
    bifl_fn_t    fn;
    bifl_copy_t  cpy;
    logic [7:0]  c [8];
    logic [32:0] q [$];
    integer      seed = 55303;
    int          bad_count = 0;
    int          n_tests = 0;

    always #2 pclk = ~pclk;

    bifl_top #(.SET_DELAY(SET_DELAY)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .terminal_in(term), .speed_actual(spd), .set_request(set_req), .fn_out(fn),
        .speed_ctrl_actual(sca), .torque_setpoint_source(src_out), .torque_limit_a(lim_a),
        .torque_limit_b(lim_b), .rs485_tx_out(tx_out), .rs485_tx_oe(tx_oe),
        .rs485_rx_enable(rx_en), .serial_tx_data(tx_data), .active_set_indicator(act),
        .display_set_selector(disp), .set_copy_command(cpy), .set_copy_start(copy_go));
    bifl_switch_model u_sw (.pclk(pclk), .want(want), .terminal_in(term),
        .serial_tx_data(tx_data));

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        q.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // read data is judged at the very edge that completes the access
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            cmp("prdata", q[0][31:0], prdata);
            cmp("pslverr", {31'h0, q[0][32]}, {31'h0, pslverr});
            void'(q.pop_front());
        end
    end

    function automatic bifl_fn_t exp_fn(input logic [7:0] t);
        bifl_fn_t    f;
        logic [7:0]  asg, hi_any, hi_all;
        logic [15:0] mag;
        int          k;
        asg = 8'h00;
        hi_any = 8'h00;
        hi_all = 8'hff;
        for (int i = 0; i < 8; i++) begin
            if (c[i] >= FN_TECH_DROOP && c[i] <= FN_MAIN_SETP) begin
                k = int'(c[i] - FN_TECH_DROOP);
                asg[k] = 1'b1;
                hi_any[k] = hi_any[k] | t[i];
                hi_all[k] = hi_all[k] & t[i];
            end
        end
        mag = spd[15] ? -spd : spd;
        f.tech_droop = (!asg[0] || hi_any[0]) && tda != 8'h00;
        f.speed_droop = (!asg[1] || hi_all[1]) && sda != 8'h00;
        f.pi_to_p_enable = asg[2] && hi_all[2];
        f.p_mode = f.pi_to_p_enable && mag > thr;
        f.inertia_comp = !asg[3] || hi_all[3];
        f.speed_invert = hi_any[4];
        f.slave = hi_any[5];
        f.torque_alt = hi_any[6] && mag > chg;
        f.main_setpoint_on = !asg[7] || hi_all[7];
        return f;
    endfunction : exp_fn

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end

    initial begin
        logic [31:0] cw, lp, la;
        bifl_fn_t    f;
        logic [5:0]  src;
        int          sv;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 32'h20; a += 4)
            if (a != 32'h14) rd(8'(a), 32'h0, a == 32'h20);
        rd(8'h02, 32'h0, 1'b1);
        $display("test reset_and_map done");
        for (int s = 0; s < 4; s++) begin
            cw = {22'h0, 1'b1, s[0], 2'(3 - s), 2'(s), 2'h0, 2'(3 - s)};
            set_req <= 2'(s);
            apb(1'b1, ADDR_SETCTL, cw);
            rd(ADDR_SETCTL, cw & 32'h1f3, 1'b0);
            repeat (SET_DELAY / 2) @(posedge pclk);
            cmp("active_early", (s == 0) ? 32'h0 : 32'(s - 1), {30'h0, act});
            repeat (SET_DELAY) @(posedge pclk);
            cmp("active_set", 32'(s), {30'h0, act});
            cmp("display_set", 32'(3 - s), {30'h0, disp});
            cmp("copy_cmd", {27'h0, cw[8:7], cw[6:5], cw[4]}, {27'h0, cpy});
        end
        $display("test parameter_sets done");
        for (int it = 0; it < 40; it++) begin
            for (int i = 0; i < 8; i++) begin
                c[i] = 8'h24 + 8'($random(seed) & 7);
                if (($random(seed) & 3) == 0) c[i] = 8'h00;
            end
            tda = (it % 5 == 0) ? 8'h00 : 8'($random(seed));
            sda = (it % 7 == 0) ? 8'h00 : 8'($random(seed));
            src = 6'($random(seed));
            sv = $random(seed) % 30000;
            thr = (it % 4 == 1) ? 16'(sv < 0 ? -sv : sv) : 16'($random(seed) & 32'h7fff);
            chg = (it % 4 == 2) ? 16'(sv < 0 ? -sv : sv) : 16'($random(seed) & 32'h7fff);
            lp = $random(seed);
            la = $random(seed);
            apb(1'b1, ADDR_SEL_LO, {c[3], c[2], c[1], c[0]});
            apb(1'b1, ADDR_SEL_HI, {c[7], c[6], c[5], c[4]});
            apb(1'b1, ADDR_CFG, {2'h0, src, 4'h0, it[0] ? 4'h4 : 4'h2, sda, tda});
            apb(1'b1, ADDR_SPEED, {chg, thr});
            apb(1'b1, ADDR_LIM_PRI, lp);
            apb(1'b1, ADDR_LIM_ALT, la);
            apb(1'b1, ADDR_STATUS, 32'hffffffff);
            want <= 8'($random(seed));
            spd <= 16'(sv);
            repeat (CTRL_CYCLES + 12) @(posedge pclk);
            f = exp_fn(want);
            rd(ADDR_STATUS, {4'h3, 4'h0, want, 7'h0, f}, 1'b0);
            cmp("speed_ctrl", {16'h0, f.speed_invert ? -spd : spd}, {16'h0, sca});
            cmp("trq_source", {26'h0, f.slave ? src : 6'h00}, {26'h0, src_out});
            cmp("trq_limits", f.torque_alt ? la : lp, {lim_b, lim_a});
            cmp("bus_dir", {30'h0, it[0] ? {!f.slave, f.slave} : 2'h3}, {30'h0, tx_oe, rx_en});
        end
        $display("test terminal_functions done");
        wrap_up();
    end
endmodule : bifl_top_tb

bind bifl_top bifl_props #(.SET_DELAY(SET_DELAY)) u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .fn_out, .speed_actual,
    .speed_ctrl_actual, .torque_setpoint_source, .rs485_tx_out, .rs485_tx_oe,
    .rs485_rx_enable, .serial_tx_data, .set_request, .active_set_indicator, .set_copy_start);
